// ==== rtl/sfq_cmd_front.v ====
/*
 * serial flash command front end for memory read and page program.
 * assumes the serial pins are asynchronous and sampled at 100 MHz with
 * the serial clock at most a tenth of that; the array answers rd_data_i
 * for rd_addr_o within one clock and accepts program writes by valid/ready.
 */
`include "sfq_defs.vh"

module sfq_cmd_front #(
	parameter [23:0] PGM_CYCLES = (`SFQ_PGM_NS + `SFQ_CLK_NS - 1) / `SFQ_CLK_NS,
	parameter [23:0] PGM_TIMEOUT_CYCLES = `SFQ_PGM_TIMEOUT_NS / `SFQ_CLK_NS
) (
	input wire ref_clk_i,
	input wire nrst_i,
	input wire select_low_active_i,
	input wire sclk_i,
	input wire [3:0] dq_i,
	output wire [3:0] dq_o,
	output wire [3:0] dq_oe_o,
	input wire [1:0] proto_i,
	input wire [3:0] dummy_cycles_i,
	input wire wel_set_i,
	input wire flag_clr_i,
	input wire suspend_i,
	input wire resume_i,
	output wire [7:0] prot_sector_o,
	input wire prot_hit_i,
	output wire [23:0] rd_addr_o,
	input wire [7:0] rd_data_i,
	output wire pw_valid_o,
	output wire [23:0] pw_addr_o,
	output wire [7:0] pw_data_o,
	input wire pw_ready_i,
	output wire wip_o,
	output wire wel_o,
	output reg [7:0] flag_status_o
);
	localparam [2:0] ST_CMD = 3'h0;
	localparam [2:0] ST_ADDR = 3'h1;
	localparam [2:0] ST_DUMMY = 3'h2;
	localparam [2:0] ST_RDATA = 3'h3;
	localparam [2:0] ST_PDATA = 3'h4;
	localparam [2:0] ST_IGN = 3'h5;

	function [2:0] lanes;
		input [1:0] p;
		begin
			if (p == `SFQ_PROTO_DUAL) lanes = 3'h2;
			else if (p == `SFQ_PROTO_QUAD) lanes = 3'h4;
			else lanes = 3'h1;
		end
	endfunction

	function [23:0] shin;
		input [23:0] s;
		input [3:0] d;
		input [2:0] w;
		begin
			case (w)
				3'h2: shin = {s[21:0], d[1:0]};
				3'h4: shin = {s[19:0], d};
				default: shin = {s[22:0], d[0]};
			endcase
		end
	endfunction

	function is_pgm;
		input [7:0] op;
		begin
			is_pgm = (op == `SFQ_OP_PP) || (op == `SFQ_OP_DPP) || (op == `SFQ_OP_EDPP) ||
				(op == `SFQ_OP_QPP) || (op == `SFQ_OP_EQPP);
		end
	endfunction

	function ok_op;
		input [7:0] op;
		input [1:0] p;
		begin
			if (p == `SFQ_PROTO_EXT) begin
				ok_op = is_pgm(op) || (op == `SFQ_OP_READ) || (op == `SFQ_OP_FAST) ||
					(op == `SFQ_OP_DOUT) || (op == `SFQ_OP_DIO) ||
					(op == `SFQ_OP_QOUT) || (op == `SFQ_OP_QIO);
			end else if (p == `SFQ_PROTO_DUAL) begin
				ok_op = (op == `SFQ_OP_FAST) || (op == `SFQ_OP_DOUT) || (op == `SFQ_OP_DIO) ||
					(op == `SFQ_OP_PP) || (op == `SFQ_OP_DPP) || (op == `SFQ_OP_EDPP);
			end else if (p == `SFQ_PROTO_QUAD) begin
				ok_op = (op == `SFQ_OP_FAST) || (op == `SFQ_OP_QOUT) || (op == `SFQ_OP_QIO) ||
					(op == `SFQ_OP_PP) || (op == `SFQ_OP_QPP) || (op == `SFQ_OP_EQPP);
			end else begin
				ok_op = 1'b0;
			end
		end
	endfunction

	// address lanes; outside extended protocol every phase uses the protocol width
	function [2:0] addr_w;
		input [7:0] op;
		input [1:0] p;
		begin
			if (p != `SFQ_PROTO_EXT) addr_w = lanes(p);
			else if (op == `SFQ_OP_DIO || op == `SFQ_OP_EDPP) addr_w = 3'h2;
			else if (op == `SFQ_OP_QIO || op == `SFQ_OP_EQPP) addr_w = 3'h4;
			else addr_w = 3'h1;
		end
	endfunction

	function [2:0] data_w;
		input [7:0] op;
		input [1:0] p;
		begin
			if (p != `SFQ_PROTO_EXT) data_w = lanes(p);
			else if (op == `SFQ_OP_DOUT || op == `SFQ_OP_DIO || op == `SFQ_OP_DPP ||
				op == `SFQ_OP_EDPP) data_w = 3'h2;
			else if (op == `SFQ_OP_QOUT || op == `SFQ_OP_QIO || op == `SFQ_OP_QPP ||
				op == `SFQ_OP_EQPP) data_w = 3'h4;
			else data_w = 3'h1;
		end
	endfunction

	// pin synchronisers: select, serial clock and data lanes in one bank
	reg [5:0] s1_q;
	reg [5:0] s2_q;
	reg sel3_q;
	reg sclk3_q;
	wire sel_s = s2_q[5];
	wire [3:0] dq_s = s2_q[3:0];
	wire rise = s2_q[4] & ~sclk3_q & ~sel_s;
	wire fall = ~s2_q[4] & sclk3_q & ~sel_s;
	wire sel_up = sel_s & ~sel3_q;

	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s1_q <= 6'h20;
			s2_q <= 6'h20;
			sel3_q <= 1'b1;
			sclk3_q <= 1'b0;
		end else begin
			s1_q <= {select_low_active_i, sclk_i, dq_i};
			s2_q <= s1_q;
			sel3_q <= s2_q[5];
			sclk3_q <= s2_q[4];
		end
	end

	reg [2:0] st_q;
	reg [7:0] op_q;
	reg [23:0] sh_q;
	reg [4:0] cnt_q;
	reg [2:0] w_q;
	reg [23:0] addr_q;
	reg [2:0] ocnt_q;
	reg [7:0] obyte_q;
	reg [3:0] dq_q;
	reg [3:0] oe_q;
	reg [7:0] pg_idx_q;
	reg got_q;
	reg [255:0] mask_q;
	reg wip_q;
	reg wel_q;
	reg susp_q;

	wire [23:0] sh_nx = shin(sh_q, dq_s, w_q);
	wire [4:0] cnt_nx = cnt_q + {2'h0, w_q};
	wire byte_end = (cnt_nx == `SFQ_BYTE_BITS);
	wire [7:0] cur_b = (ocnt_q == 3'h0) ? rd_data_i : obyte_q;
	wire mem_we = rise && (st_q == ST_PDATA) && byte_end;
	// only whole bytes count: a select edge mid-byte leaves cnt_q nonzero
	wire pgm_go = sel_up && (st_q == ST_PDATA) && got_q && (cnt_q == 5'h0) && wel_q &&
		~wip_q;
	wire pgm_start = pgm_go & ~prot_hit_i;

	assign dq_o = dq_q;
	assign dq_oe_o = oe_q;
	assign rd_addr_o = addr_q;
	assign prot_sector_o = addr_q[23:16];

	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q <= ST_CMD;
			op_q <= 8'h00;
			sh_q <= 24'h000000;
			cnt_q <= 5'h00;
			w_q <= 3'h1;
			addr_q <= 24'h000000;
			ocnt_q <= 3'h0;
			obyte_q <= 8'h00;
			dq_q <= 4'h0;
			oe_q <= 4'h0;
			pg_idx_q <= 8'h00;
			got_q <= 1'b0;
			mask_q <= 256'h0;
		end else if (sel_s) begin
			st_q <= ST_CMD;
			cnt_q <= 5'h00;
			ocnt_q <= 3'h0;
			oe_q <= 4'h0;
			w_q <= lanes(proto_i);
		end else if (rise) begin
			case (st_q)
				ST_CMD: begin
					sh_q <= sh_nx;
					if (byte_end) begin
						op_q <= sh_nx[7:0];
						cnt_q <= 5'h00;
						// busy programs refuse a second program outright
						if (ok_op(sh_nx[7:0], proto_i) && !(is_pgm(sh_nx[7:0]) && wip_q)) begin
							st_q <= ST_ADDR;
							w_q <= addr_w(sh_nx[7:0], proto_i);
						end else begin
							st_q <= ST_IGN;
						end
					end else begin
						cnt_q <= cnt_nx;
					end
				end
				ST_ADDR: begin
					sh_q <= sh_nx;
					if (cnt_nx == `SFQ_ADDR_BITS) begin
						addr_q <= sh_nx;
						pg_idx_q <= sh_nx[7:0];
						got_q <= 1'b0;
						mask_q <= 256'h0;
						cnt_q <= 5'h00;
						w_q <= data_w(op_q, proto_i);
						if (is_pgm(op_q)) begin
							st_q <= ST_PDATA;
						end else if (op_q == `SFQ_OP_READ || dummy_cycles_i == 4'h0) begin
							st_q <= ST_RDATA;
						end else begin
							st_q <= ST_DUMMY;
						end
					end else begin
						cnt_q <= cnt_nx;
					end
				end
				ST_DUMMY: begin
					if (cnt_q + 5'h01 == {1'b0, dummy_cycles_i}) begin
						st_q <= ST_RDATA;
						cnt_q <= 5'h00;
					end else begin
						cnt_q <= cnt_q + 5'h01;
					end
				end
				ST_PDATA: begin
					sh_q <= sh_nx;
					if (byte_end) begin
						cnt_q <= 5'h00;
						pg_idx_q <= pg_idx_q + 8'h01;
						mask_q[pg_idx_q] <= 1'b1;
						got_q <= 1'b1;
					end else begin
						cnt_q <= cnt_nx;
					end
				end
				default: begin
				end
			endcase
		end else if (fall && st_q == ST_RDATA) begin
			// data leaves on the falling edge so the host samples it on the next rise
			case (w_q)
				3'h2: begin
					dq_q <= {2'h0, cur_b[7:6]};
					oe_q <= 4'h3;
				end
				3'h4: begin
					dq_q <= cur_b[7:4];
					oe_q <= 4'hf;
				end
				default: begin
					dq_q <= {2'h0, cur_b[7], 1'b0};
					oe_q <= 4'h2;
				end
			endcase
			obyte_q <= cur_b << w_q;
			ocnt_q <= ocnt_q + w_q;
			if (ocnt_q == 3'h0) begin
				addr_q <= addr_q + 24'h000001;
			end
		end
	end

	// program drain: walk the page buffer, push marked bytes into a 2-entry buffer
	reg [15:0] pgm_page_q;
	reg [23:0] tmr_q;
	reg [8:0] drain_idx_q;
	reg stg_v_q;
	reg [7:0] stg_idx_q;
	reg [31:0] e0_q;
	reg [31:0] e1_q;
	reg [1:0] f_cnt_q;
	reg fs_prot_q;
	reg fs_fail_q;
	wire [7:0] mem_rdata;

	wire pgm_run = wip_q & ~susp_q;
	wire need_push = stg_v_q & mask_q[stg_idx_q];
	wire f_in_rdy = (f_cnt_q != 2'h2);
	wire adv = pgm_run & (~need_push | f_in_rdy);
	wire f_push = pgm_run & need_push & f_in_rdy;
	wire f_pop = pw_valid_o & pw_ready_i;
	wire drain_done = drain_idx_q[8] & ~stg_v_q & (f_cnt_q == 2'h0);
	wire pgm_done = wip_q & drain_done & (tmr_q >= PGM_CYCLES - 24'h000001);
	wire pgm_tout = wip_q & ~pgm_done & (tmr_q >= PGM_TIMEOUT_CYCLES - 24'h000001);
	// hold the read address on a stall so the staged byte stays valid
	wire [7:0] mem_raddr = adv ? drain_idx_q[7:0] : stg_idx_q;

	assign pw_valid_o = (f_cnt_q != 2'h0);
	assign pw_addr_o = e0_q[31:8];
	assign pw_data_o = e0_q[7:0];
	assign wip_o = wip_q;
	assign wel_o = wel_q;

	sfq_page_mem #(
		.DW(8),
		.AW(8)
	) u_page (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.we_i(mem_we),
		.waddr_i(pg_idx_q),
		.wdata_i(sh_nx[7:0]),
		.raddr_i(mem_raddr),
		.rdata_o(mem_rdata)
	);

	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wip_q <= 1'b0;
			wel_q <= 1'b0;
			susp_q <= 1'b0;
			fs_prot_q <= 1'b0;
			fs_fail_q <= 1'b0;
			pgm_page_q <= 16'h0000;
			tmr_q <= 24'h000000;
			drain_idx_q <= 9'h100;
			stg_v_q <= 1'b0;
			stg_idx_q <= 8'h00;
		end else begin
			if (wel_set_i) begin
				wel_q <= 1'b1;
			end else if (pgm_start || pgm_tout) begin
				wel_q <= 1'b0;
			end
			if (pgm_go && prot_hit_i) begin
				fs_prot_q <= 1'b1;
			end else if (flag_clr_i) begin
				fs_prot_q <= 1'b0;
			end
			if (pgm_tout || (pgm_go && prot_hit_i)) begin
				fs_fail_q <= 1'b1;
			end else if (flag_clr_i) begin
				fs_fail_q <= 1'b0;
			end
			if (pgm_start) begin
				wip_q <= 1'b1;
				susp_q <= 1'b0;
				tmr_q <= 24'h000000;
				drain_idx_q <= 9'h000;
				stg_v_q <= 1'b0;
				pgm_page_q <= addr_q[23:8];
			end else if (wip_q) begin
				if (suspend_i && !susp_q) begin
					susp_q <= 1'b1;
				end else if (resume_i) begin
					susp_q <= 1'b0;
				end
				if (pgm_run) begin
					tmr_q <= tmr_q + 24'h000001;
				end
				if (adv) begin
					stg_v_q <= ~drain_idx_q[8];
					stg_idx_q <= drain_idx_q[7:0];
					if (!drain_idx_q[8]) begin
						drain_idx_q <= drain_idx_q + 9'h001;
					end
				end
				if (pgm_done || pgm_tout) begin
					wip_q <= 1'b0;
					susp_q <= 1'b0;
					stg_v_q <= 1'b0;
					drain_idx_q <= 9'h100;
				end
			end
		end
	end

	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			e0_q <= 32'h00000000;
			e1_q <= 32'h00000000;
			f_cnt_q <= 2'h0;
		end else if (pgm_tout) begin
			f_cnt_q <= 2'h0;
		end else if (f_push && !f_pop) begin
			if (f_cnt_q == 2'h0) begin
				e0_q <= {pgm_page_q, stg_idx_q, mem_rdata};
			end else begin
				e1_q <= {pgm_page_q, stg_idx_q, mem_rdata};
			end
			f_cnt_q <= f_cnt_q + 2'h1;
		end else if (f_pop && !f_push) begin
			e0_q <= e1_q;
			f_cnt_q <= f_cnt_q - 2'h1;
		end else if (f_pop && f_push) begin
			if (f_cnt_q == 2'h1) begin
				e0_q <= {pgm_page_q, stg_idx_q, mem_rdata};
			end else begin
				e0_q <= e1_q;
				e1_q <= {pgm_page_q, stg_idx_q, mem_rdata};
			end
		end
	end

	always @* begin
		flag_status_o = 8'h00;
		flag_status_o[`SFQ_FS_READY] = ~wip_q | susp_q;
		flag_status_o[`SFQ_FS_PFAIL] = fs_fail_q;
		flag_status_o[`SFQ_FS_PSUSP] = susp_q;
		flag_status_o[`SFQ_FS_PROT] = fs_prot_q;
	end
endmodule // sfq_cmd_front

// ==== rtl/sfq_defs.vh ====
/*
 * constants for the serial flash read/program command front end:
 * opcodes, protocol codes, flag bit positions, reset values and timing.
 * assumes a 100 MHz system clock; included by bare name.
 */
// Functional notes
// - every read and program command carries a 24-bit byte address, three bytes.
// - address bits are sampled on the rising serial clock edge.
// - read address increments after each output byte; whole array readable.
// - select high during read output stops driving and ends the command.
// - decode read opcodes 03, 0b, 3b, bb, 6b, eb with their lane use.
// - dual and quad protocols accept only their listed reads; behaviour identical.
// - fast read variants insert dummy cycles before data; plain read has none.
// - select rising at a valid point starts the self-timed program cycle.
// - bytes past the page end wrap to the start of the same page.
// - more than a page of bytes keeps only the last page-size bytes.
// - fewer bytes program only addressed bytes; rest of page untouched.
// - write-in-progress reads 1 while programming; write enable latch clears.
// - status and flags readable during program; suspend and resume pause it.
// - program timeout resets write enable latch and sets program-fail flag.
// - select rising off a byte boundary: no program, no flags, latch kept.
// - program to protected sector: not executed, latch kept, flags 1 and 4.
// - program variants use line zero, two or four lanes as listed.
// - page write in all protocols; dual/quad variants only in matching ones.
`ifndef SFQ_DEFS_VH
`define SFQ_DEFS_VH

`define SFQ_OP_READ 8'h03
`define SFQ_OP_FAST 8'h0b
`define SFQ_OP_DOUT 8'h3b
`define SFQ_OP_DIO 8'hbb
`define SFQ_OP_QOUT 8'h6b
`define SFQ_OP_QIO 8'heb
`define SFQ_OP_PP 8'h02
`define SFQ_OP_DPP 8'ha2
`define SFQ_OP_EDPP 8'hd2
`define SFQ_OP_QPP 8'h32
`define SFQ_OP_EQPP 8'h12

`define SFQ_PROTO_EXT 2'h0
`define SFQ_PROTO_DUAL 2'h1
`define SFQ_PROTO_QUAD 2'h2

`define SFQ_BYTE_BITS 5'h08
`define SFQ_ADDR_BITS 5'h18

`define SFQ_FS_READY 7
`define SFQ_FS_PFAIL 4
`define SFQ_FS_PSUSP 2
`define SFQ_FS_PROT 1
`define SFQ_FS_RESET 8'h80

`define SFQ_CLK_NS 10
`define SFQ_PGM_NS 500000
`define SFQ_PGM_TIMEOUT_NS 5000000

`endif

// ==== rtl/sfq_page_mem.v ====
/*
 * page buffer: single write port, registered read port.
 * assumes one clock; contents are not reset, only the read register is.
 */
module sfq_page_mem #(
	parameter DW = 8,
	parameter AW = 8
) (
	input wire ref_clk_i,
	input wire nrst_i,
	input wire we_i,
	input wire [AW-1:0] waddr_i,
	input wire [DW-1:0] wdata_i,
	input wire [AW-1:0] raddr_i,
	output reg [DW-1:0] rdata_o
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge ref_clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_o <= {DW{1'b0}};
		end else begin
			rdata_o <= mem[raddr_i];
		end
	end
endmodule // sfq_page_mem

// ==== dv/sfq_cmd_front_properties.sv ====
/* port checker for sfq_cmd_front.
   assumes one clock domain; bound at the foot of this file. */
module sfq_cmd_front_properties (
	input wire ref_clk_i,
	input wire nrst_i,
	input wire select_low_active_i,
	input wire [3:0] dq_oe_o,
	input wire [7:0] prot_sector_o,
	input wire [23:0] rd_addr_o,
	input wire pw_valid_o,
	input wire [23:0] pw_addr_o,
	input wire [7:0] pw_data_o,
	input wire pw_ready_i,
	input wire wip_o,
	input wire wel_o,
	input wire [7:0] flag_status_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	a_ready_vs_busy: assert property (!flag_status_o[2] |-> flag_status_o[7] == !wip_o)
		else $error("ready flag disagrees with busy");
	a_start_drops_wel: assert property ($rose(wip_o) |-> ##[0:2] !wel_o)
		else $error("latch still set after program start");
	a_idle_quiet: assert property (select_low_active_i [*6] |-> dq_oe_o == 4'h0)
		else $error("lanes driven while deselected");
	a_lane_set: assert property (dq_oe_o inside {4'h0, 4'h2, 4'h3, 4'hf})
		else $error("illegal lane enable");
	// a timed-out program flushes the buffer, so only a running one must hold
	a_write_held: assert property (pw_valid_o && !pw_ready_i |=>
		!wip_o || (pw_valid_o && $stable(pw_addr_o) && $stable(pw_data_o)))
		else $error("array write dropped while stalled");
	a_write_in_page: assert property (pw_valid_o |-> wip_o && pw_addr_o[23:16] == prot_sector_o)
		else $error("array write outside program");
	a_prot_error: assert property ($rose(flag_status_o[1]) |->
		flag_status_o[4] && wel_o && !wip_o)
		else $error("protection error with wrong side effects");
	a_read_step: assert property (dq_oe_o != 4'h0 && $past(dq_oe_o) != 4'h0 &&
		rd_addr_o != $past(rd_addr_o) |-> rd_addr_o == $past(rd_addr_o) + 24'h1)
		else $error("read address skipped");
	a_fail_clears: assert property ($rose(flag_status_o[4]) && !flag_status_o[1] |->
		##[0:1] (!wel_o && !wip_o))
		else $error("failed program left busy or latch");
endmodule // sfq_cmd_front_properties

bind sfq_cmd_front sfq_cmd_front_properties u_sfq_cmd_front_properties (.ref_clk_i, .nrst_i,
	.select_low_active_i, .dq_oe_o, .prot_sector_o, .rd_addr_o, .pw_valid_o, .pw_addr_o,
	.pw_data_o, .pw_ready_i, .wip_o, .wel_o, .flag_status_o);

// ==== dv/sfq_host_model.sv ====
/* host serial controller: select, mode 0 serial clock, up to four lanes.
   assumes a 100 MHz ref clock; each clock phase lasts five ref clocks. */
module sfq_host_model (
	input wire logic ref_clk_i,
	input wire logic [3:0] dq_i,
	output logic sel_n_o,
	output logic sclk_o,
	output logic [3:0] dq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sel_n_o = 1'b1;
		sclk_o = 1'b0;
		dq_o = 4'h0;
	end
	// long phases keep clear of the device's two-flop pin sync
	task automatic tick();
		repeat (5) @(posedge ref_clk_i);
	endtask
	task automatic start();
		@(posedge ref_clk_i);
		sel_n_o <= 1'b0;
		tick();
	endtask
	task automatic stop();
		tick();
		sel_n_o <= 1'b1;
		dq_o <= ~dq_o;
		tick();
	endtask
	// msb first; unused lanes toggle on single-lane sends so no stale level looks valid, but sit low on dual-lane ones
	task automatic send(input logic [31:0] v, input int n, input int w);
		logic [3:0] m;
		m = 4'((1 << w) - 1);
		for (int i = n - w; i >= 0; i -= w) begin
			dq_o <= (4'(v >> i) & m) | (~m & {4{i[0]}});
			tick();
			sclk_o <= 1'b1;
			tick();
			sclk_o <= 1'b0;
		end
	endtask
	task automatic recv(output logic [31:0] v, input int n, input int w);
		v = 32'h0;
		for (int i = 0; i < n; i += w) begin
			tick();
			v = (v << w) | 32'(w == 1 ? dq_i[1] : dq_i & 4'((1 << w) - 1));
			sclk_o <= 1'b1;
			tick();
			sclk_o <= 1'b0;
		end
	endtask
endmodule // sfq_host_model

// ==== dv/tb_sfq_cmd_front.sv ====
/* bench for sfq_cmd_front: serial reads and programs through the host model.
   assumes a stalling array model here and short program timers. */
module tb_sfq_cmd_front;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i, nrst_i, sel_n, sclk, wel_set_i, flag_clr_i, pw_ready_i, hold_q, tg;
	logic suspend_i, resume_i;
	logic [3:0] dq_h, dq_o, dq_oe_o, dummy_cycles_i;
	logic [1:0] proto_i;
	logic [7:0] prot_sector_o, pw_data_o, flag_status_o;
	logic [23:0] rd_addr_o, pw_addr_o;
	logic pw_valid_o, wip_o, wel_o;
	logic [31:0] got;
	logic [7:0] mem [int];
	int err_total, checks, k, tn;
	wire [3:0] dq_w = (dq_oe_o & dq_o) | (~dq_oe_o & {4{tg}});
	// op, protocol, command, address and data lanes
	localparam logic [23:0] CMD_TAB [11] = '{24'h0b0111, 24'h3b0112, 24'hbb0122, 24'h6b0114,
		24'heb0144, 24'h0b1222, 24'h3b1222, 24'hbb1222, 24'h0b2444, 24'h6b2444, 24'heb2444};
	function automatic logic [7:0] rdv(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5a;
	endfunction
	sfq_host_model u_sfq_host_model (.ref_clk_i, .dq_i(dq_w), .sel_n_o(sel_n), .sclk_o(sclk),
		.dq_o(dq_h));
	sfq_cmd_front #(.PGM_CYCLES(24'h14), .PGM_TIMEOUT_CYCLES(24'h7d0)) u_sfq_cmd_front (
		.ref_clk_i, .nrst_i, .select_low_active_i(sel_n), .sclk_i(sclk), .dq_i(dq_h), .dq_o,
		.dq_oe_o, .proto_i, .dummy_cycles_i, .wel_set_i, .flag_clr_i, .suspend_i,
		.resume_i, .prot_sector_o, .prot_hit_i(prot_sector_o == 8'h7f), .rd_addr_o,
		.rd_data_i(rdv(rd_addr_o)), .pw_valid_o, .pw_addr_o, .pw_data_o, .pw_ready_i, .wip_o,
		.wel_o, .flag_status_o);
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	// array takes every other cycle, or nothing while hold_q forces a timeout
	always @(posedge ref_clk_i) begin
		tg <= ~tg;
		pw_ready_i <= !hold_q && !pw_ready_i;
		if (pw_valid_o && pw_ready_i)
			mem[pw_addr_o] = pw_data_o;
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic done();
		tn++;
		$display("test %0d done", tn);
	endtask
	task automatic rd(input logic [7:0] op, input logic [23:0] a, input int cw, aw, dw, dm, nb);
		u_sfq_host_model.start();
		u_sfq_host_model.send(op, 8, cw);
		u_sfq_host_model.send(a, 24, aw);
		u_sfq_host_model.send(0, dm, 1);
		for (int b = 0; b < nb; b++) begin
			u_sfq_host_model.recv(got, 8, dw);
			cmp(got, rdv(a + b));
		end
		u_sfq_host_model.stop();
	endtask
	task automatic pg(input logic [7:0] op, input logic [23:0] a, input int cw, aw, dw, nb, xb);
		u_sfq_host_model.start();
		u_sfq_host_model.send(op, 8, cw);
		u_sfq_host_model.send(a, 24, aw);
		for (int b = 0; b < nb; b++)
			u_sfq_host_model.send(b + 1, 8, dw);
		u_sfq_host_model.send(0, xb, 1);
		u_sfq_host_model.stop();
	endtask
	task automatic pulse(input int f);
		@(posedge ref_clk_i);
		wel_set_i <= f == 0;
		flag_clr_i <= f == 1;
		suspend_i <= f == 2;
		resume_i <= f == 3;
		@(posedge ref_clk_i);
		wel_set_i <= 1'b0;
		flag_clr_i <= 1'b0;
		suspend_i <= 1'b0;
		resume_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
	endtask
	task automatic wait_idle();
		for (k = 0; k < 5000 && wip_o !== 1'b0; k++)
			@(posedge ref_clk_i);
		if (k == 5000) begin
			err_total++;
			print_verdict();
		end
	endtask
	initial begin
		nrst_i = 1'b0;
		wel_set_i = 1'b0;
		flag_clr_i = 1'b0;
		suspend_i = 1'b0;
		resume_i = 1'b0;
		hold_q = 1'b0;
		tg = 1'b0;
		pw_ready_i = 1'b0;
		proto_i = 2'h0;
		dummy_cycles_i = 4'h4;
		repeat (6) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		cmp({wip_o, wel_o, flag_status_o, dq_oe_o}, {2'h0, 8'h80, 4'h0});
		done();
		rd(8'h03, 24'hfffffe, 1, 1, 1, 0, 3);
		done();
		for (int i = 0; i < 11; i++) begin
			proto_i <= CMD_TAB[i][13:12];
			rd(CMD_TAB[i][23:16], 24'h0123f0 + i, CMD_TAB[i][11:8], CMD_TAB[i][7:4],
				CMD_TAB[i][3:0], 4, 2);
		end
		done();
		proto_i <= 2'h2;
		u_sfq_host_model.start();
		u_sfq_host_model.send(8'h03, 8, 4);
		u_sfq_host_model.send(24'h000010, 24, 4);
		u_sfq_host_model.recv(got, 8, 4);
		cmp(dq_oe_o, 4'h0);
		u_sfq_host_model.stop();
		proto_i <= 2'h0;
		pg(8'h02, 24'h0100fe, 1, 1, 1, 2, 0);
		cmp({wip_o, wel_o, flag_status_o}, {2'h0, 8'h80});
		done();
		pulse(0);
		pg(8'h02, 24'h0100fe, 1, 1, 1, 3, 0);
		cmp({wip_o, wel_o}, 2'h2);
		wait_idle();
		cmp({mem[32'h0100fe], mem[32'h0100ff], mem[32'h010000]}, 24'h010203);
		cmp(mem.exists(32'h010001), 0);
		pulse(0);
		pg(8'h32, 24'h020000, 1, 1, 4, 257, 0);
		wait_idle();
		cmp({mem[32'h020000], mem[32'h0200ff]}, 16'h0100);
		done();
		pulse(0);
		proto_i <= 2'h1;
		pg(8'hd2, 24'h030010, 2, 2, 2, 1, 0);
		wait_idle();
		cmp(mem[32'h030010], 8'h01);
		pulse(0);
		proto_i <= 2'h2;
		pg(8'ha2, 24'h030020, 4, 4, 2, 1, 0);
		cmp({wip_o, wel_o}, 2'h1);
		proto_i <= 2'h0;
		pg(8'h02, 24'h030030, 1, 1, 1, 1, 4);
		cmp({wip_o, wel_o, flag_status_o}, {2'h1, 8'h80});
		pg(8'h02, 24'h7f0000, 1, 1, 1, 1, 0);
		cmp({wip_o, wel_o, flag_status_o}, {2'h1, 8'h92});
		pulse(1);
		cmp(flag_status_o, 8'h80);
		pg(8'h02, 24'h050000, 1, 1, 1, 1, 0);
		pulse(2);
		cmp({wip_o, wel_o, flag_status_o}, {2'h2, 8'h84});
		pulse(3);
		wait_idle();
		cmp(mem[32'h050000], 8'h01);
		pulse(0);
		done();
		hold_q <= 1'b1;
		pg(8'h02, 24'h040000, 1, 1, 1, 2, 0);
		wait_idle();
		cmp({wip_o, wel_o, flag_status_o}, {2'h0, 8'h90});
		hold_q <= 1'b0;
		done();
		print_verdict();
	end
endmodule // tb_sfq_cmd_front
